/* File: design/hies_err_if.sv */
`default_nettype none
interface hies_err_if;
  logic ill_ev;
  logic sq_ev;
  logic dp_ev;
  logic mp_ev;
  logic sq_chk_off;
  logic dp_chk_on;
  logic mp_chk_on;
  logic par_clr;
  logic ill_clr;
  hies_pkg::hies_err_t err;
  modport owner (output ill_ev, sq_ev, dp_ev, mp_ev, sq_chk_off, dp_chk_on, mp_chk_on,
    par_clr, ill_clr, input err);
  modport latch (input ill_ev, sq_ev, dp_ev, mp_ev, sq_chk_off, dp_chk_on, mp_chk_on,
    par_clr, ill_clr, output err);
endinterface
`default_nettype wire

/* File: design/hies_err_latch.sv */
`default_nettype none
module hies_err_latch (
  input wire logic core_clk,
  input wire logic reset,
  input wire logic clk_en,
  hies_err_if.latch e
);
  hies_pkg::hies_err_t s_q;
  hies_pkg::hies_err_t s_d;

  // each parity error sets under its own check enable, undefined always; a set beats a same-cycle clear
  always_comb begin
    s_d = s_q;
    if (e.par_clr) begin
      s_d.sq = 1'b0;
      s_d.dp = 1'b0;
      s_d.mp = 1'b0;
    end
    if (e.ill_clr) begin
      s_d.ill = 1'b0;
    end
    if (e.ill_ev) begin
      s_d.ill = 1'b1;
    end
    if (e.sq_ev && !e.sq_chk_off) begin
      s_d.sq = 1'b1;
    end
    if (e.dp_ev && e.dp_chk_on) begin
      s_d.dp = 1'b1;
    end
    if (e.mp_ev && e.mp_chk_on) begin
      s_d.mp = 1'b1;
    end
  end

  // clock enable freezes the latches
  always_ff @(posedge core_clk) begin
    if (reset) begin
      s_q <= '0;
    end else if (clk_en) begin
      s_q <= s_d;
    end
  end

  assign e.err = s_q;
endmodule
`default_nettype wire

/* File: design/hies_irq_status.sv */
`include "hies_regs.svh"
`default_nettype none
module hies_irq_status (
  input wire logic core_clk,
  input wire logic reset,
  input wire logic clk_en,
  // host register port
  input wire logic host_wr,
  input wire logic host_rd,
  input wire logic [7:0] host_addr,
  input wire logic [7:0] host_wdata,
  output logic [7:0] host_rdata,
  // sequencer register port
  input wire logic seq_wr,
  input wire logic [7:0] seq_addr,
  input wire logic [7:0] seq_wdata,
  input wire logic [`HIES_PC_W-1:0] seq_pc,
  input wire logic [`HIES_PC_W-1:0] break_addr,
  input wire logic breakpoint_off,
  input wire logic array_access,
  input wire logic external_array_select,
  input wire logic array_arb_busy,
  output logic seq_pause,
  // error sources
  input wire logic illegal_fetch,
  input wire logic store_parity_fail,
  input wire logic datapath_parity_fail,
  input wire logic memory_parity_fail,
  input wire logic [`HIES_HB_W-1:0] host_bus_error_bits,
  // bus section events
  input wire logic bus_reset_seen,
  input wire logic bus_parity_seen,
  input wire logic sel_timeout_seen,
  input wire logic bus_free_seen,
  input wire logic [7:0] bus_events_a,
  input wire logic [7:0] bus_events_b,
  input wire logic [7:0] bus_event_mask_a,
  input wire logic [7:0] bus_event_mask_b,
  // control levels held elsewhere
  input wire logic error_halt_disable,
  input wire logic store_parity_check_off,
  input wire logic datapath_parity_check_on,
  input wire logic memory_parity_check_on,
  input wire logic irq_output_enable,
  input wire logic bus_master_allow,
  input wire logic low_power_state,
  input wire logic soft_chip_reset,
  input wire logic bus_reset_pin_n,
  // results
  output logic host_irq_line_n,
  output logic [7:0] fifo_path_control
);
  hies_pkg::hies_state_t s_q;
  hies_pkg::hies_state_t s_d;
  hies_err_if eif ();

  logic [4:0] clr;
  logic stat_wr;
  logic attn_wr;
  logic defer;
  logic bus_ev;
  logic brk_flag;
  logic hb_sum;
  logic hb_rise;
  logic gate_full;
  logic gate_done;
  logic [7:0] status_view;
  logic [7:0] error_view;
  logic [7:0] fifo_view;

  hies_err_latch u_err (
    .core_clk (core_clk),
    .reset (reset),
    .clk_en (clk_en),
    .e (eif)
  );

  // sequencer status writes; writes to the clear address are not decoded here
  assign stat_wr = seq_wr && (seq_addr == `HIES_OFS_STATUS);
  assign attn_wr = stat_wr && seq_wdata[`HIES_ST_ATTN];

  // host write ones only, plus forced clears while the bus reset is active
  always_comb begin
    clr = '0;
    if (host_wr && (host_addr == `HIES_OFS_CLEAR)) begin
      clr = host_wdata[`HIES_CL_PAR:0];
    end
    if (s_q.bus_rst) begin
      clr = `HIES_ALL_CLR;
    end
  end

  // error latches live in their own module
  assign eif.ill_ev = illegal_fetch;
  assign eif.sq_ev = store_parity_fail;
  assign eif.dp_ev = datapath_parity_fail;
  assign eif.mp_ev = memory_parity_fail;
  assign eif.sq_chk_off = store_parity_check_off;
  assign eif.dp_chk_on = datapath_parity_check_on;
  assign eif.mp_chk_on = memory_parity_check_on;
  assign eif.par_clr = clr[`HIES_CL_PAR];
  assign eif.ill_clr = soft_chip_reset || s_q.bus_rst;

  // summary follows the live host-bus bits, so writes cannot touch it
  // the external bus reset also forces the summary to zero by masking it, though the live bits stay set
  assign hb_sum = (|host_bus_error_bits) && !s_q.bus_rst;
  assign hb_rise = |(host_bus_error_bits & ~s_q.hb_prev);

  // any fault or enabled section event latches the bus-event flag
  assign bus_ev = bus_reset_seen || bus_parity_seen || sel_timeout_seen
    || bus_free_seen || |(bus_events_a & bus_event_mask_a)
    || |(bus_events_b & bus_event_mask_b);

  assign brk_flag = s_q.brk_bp || s_q.brk_ill || s_q.brk_par;

  // stalled external array access holds off the flag-driven pause
  assign defer = array_access && external_array_select && array_arb_busy;

  // attention pauses in the very cycle of its write so no instruction slips
  assign seq_pause = s_q.attn || attn_wr
    || ((s_q.bus || brk_flag) && !defer);

  // command done ignores low power; the other sources respect it
  assign gate_done = irq_output_enable && bus_master_allow;
  assign gate_full = gate_done && !low_power_state;

  // register views
  assign status_view = {s_q.code, brk_flag, s_q.bus, s_q.done, s_q.attn};
  assign error_view = {1'b0, hb_sum, eif.err.mp, eif.err.dp, eif.err.sq,
    eif.err.ill, 2'b00};
  assign fifo_view = {1'b0, s_q.fifo_req[`HIES_FC_WIDE], s_q.fifo_ack,
    s_q.fifo_req[`HIES_FC_FLUSH:`HIES_FC_RESET]};

  always_comb begin
    s_d = s_q;

    // three-stage pin capture; a change counts once stages two and three agree
    s_d.sync = {s_q.sync[1:0], ~bus_reset_pin_n};
    if (s_q.sync[1] == s_q.sync[2]) begin
      s_d.bus_rst = s_q.sync[2];
    end

    // attention and command done: clear first, sequencer set wins
    if (clr[`HIES_ST_ATTN]) begin
      s_d.attn = 1'b0;
    end
    if (clr[`HIES_ST_DONE]) begin
      s_d.done = 1'b0;
    end
    if (attn_wr) begin
      s_d.attn = 1'b1;
      s_d.code = seq_wdata[`HIES_CODE_HI:`HIES_CODE_LO];
    end
    if (stat_wr && seq_wdata[`HIES_ST_DONE]) begin
      s_d.done = 1'b1;
    end

    // bus event: driver must remove the cause first or it sets again
    if (clr[`HIES_ST_BUS]) begin
      s_d.bus = 1'b0;
    end
    if (bus_ev) begin
      s_d.bus = 1'b1;
    end

    // error flag sources each have their own release
    if (clr[`HIES_ST_BRK]) begin
      s_d.brk_bp = 1'b0;
    end
    if (soft_chip_reset || s_q.bus_rst) begin
      s_d.brk_ill = 1'b0;
    end
    if (clr[`HIES_CL_PAR]) begin
      s_d.brk_par = 1'b0;
      s_d.hb_int = 1'b0;
    end
    if (!breakpoint_off && (seq_pc == break_addr)) begin
      s_d.brk_bp = 1'b1;
    end
    if (illegal_fetch && !error_halt_disable) begin
      s_d.brk_ill = 1'b1;
    end
    if (!error_halt_disable && ((store_parity_fail && !store_parity_check_off)
        || (datapath_parity_fail && datapath_parity_check_on)
        || (memory_parity_fail && memory_parity_check_on))) begin
      s_d.brk_par = 1'b1;
    end

    // new host-bus errors latch an interrupt but never pause the sequencer
    s_d.hb_prev = host_bus_error_bits;
    if (hb_rise && !error_halt_disable && !s_q.bus_rst) begin
      s_d.hb_int = 1'b1;
    end

    // fifo control: self-clearing strobes last one cycle
    s_d.fifo_req[`HIES_FC_FLUSH] = 1'b0;
    s_d.fifo_req[`HIES_FC_RESET] = 1'b0;
    if (host_wr && (host_addr == `HIES_OFS_FIFO)) begin
      s_d.fifo_req = {1'b0, host_wdata[6:0]};
    end
    // acknowledges trail the requests by a cycle instead of following the write
    s_d.fifo_ack = s_q.fifo_req[`HIES_FC_ACK_HI:`HIES_FC_ACK_LO];
    if (soft_chip_reset || s_q.bus_rst) begin
      s_d.fifo_req = `HIES_ZERO8;
      s_d.fifo_ack = '0;
    end

    // read data is registered; unmapped addresses read zero
    s_d.rdata = `HIES_ZERO8;
    if (host_rd) begin
      unique case (host_addr)
        `HIES_OFS_STATUS: s_d.rdata = status_view;
        `HIES_OFS_CLEAR: s_d.rdata = error_view;
        `HIES_OFS_FIFO: s_d.rdata = fifo_view;
        default: s_d.rdata = `HIES_ZERO8;
      endcase
    end

    // interrupt from latched state; a flop keeps the pin free of glitches
    s_d.irq = ((s_q.attn || s_q.bus || brk_flag || s_q.hb_int) && gate_full)
      || (s_q.done && gate_done);
  end

  // one register for all state but the error latches; clock enable freezes it
  always_ff @(posedge core_clk) begin
    if (reset) begin
      s_q <= '0;
    end else if (clk_en) begin
      s_q <= s_d;
    end
  end

  assign host_rdata = s_q.rdata;
  assign host_irq_line_n = ~s_q.irq;
  assign fifo_path_control = fifo_view;
endmodule
`default_nettype wire

/* File: design/hies_pkg.sv */
`default_nettype none
package hies_pkg;
  // error latch state: undefined, store, datapath, memory
  typedef struct packed {
    logic ill;
    logic sq;
    logic dp;
    logic mp;
  } hies_err_t;
  // state of the status block apart from the error latches
  typedef struct packed {
    logic [2:0] sync;
    logic bus_rst;
    logic [3:0] code;
    logic attn;
    logic done;
    logic bus;
    logic brk_bp;
    logic brk_ill;
    logic brk_par;
    logic hb_int;
    logic [5:0] hb_prev;
    logic [7:0] fifo_req;
    logic [3:0] fifo_ack;
    logic [7:0] rdata;
    logic irq;
  } hies_state_t;
endpackage
`default_nettype wire

/* File: design/hies_regs.svh */
`ifndef HIES_REGS_SVH
`define HIES_REGS_SVH
// What this block does
// - program counter equal to break address sets error flag unless breakpoint off
// - undefined instruction and parity errors also set the error flag, per enables
// - error flag holds pause and drives interrupt under enables, not low power
// - break source cleared by clear bit 3, undefined by soft reset, parity by bit 4
// - bus-event or error pause waits for external array arbitration to finish
// - bus-event flag latches on bus faults or masked events and pauses from the next cycle
// - command-done set only by sequencer write, no pause, interrupt under enables
// - attention write pauses the sequencer at once and raises the interrupt
// - command-done and attention cleared by clear bits 1 and 0
// - clear bits act on ones only, self-clear, sequencer writes ignored
// - bus reset forces all five clear bits active; power-on reset zeroes the state
// - clear bit 4 clears parity errors and latched host-bus error interrupts
// - undefined instruction error in bit 2 clears only on soft or bus reset
// - undefined and parity errors raise error flag and pause unless halt disabled, host-bus errors do not; bus reset clears all errors
// - host-bus summary bit 6 is the OR of bits 5-0, writes do not touch it
// - memory parity error bit 5 latches only while its check is on
// - datapath parity error bit 4 latches only while its check is on
// - control-store parity error bit 3 latches unless store check is off
// - bus or soft reset zeroes fifo control; acknowledge bits follow in hardware
// - latched interrupts reach the line only with output enable and master allow
`define HIES_OFS_STATUS 8'h91
`define HIES_OFS_CLEAR 8'h92
`define HIES_OFS_FIFO 8'h93
`define HIES_ST_ATTN 0
`define HIES_ST_DONE 1
`define HIES_ST_BUS 2
`define HIES_ST_BRK 3
`define HIES_CODE_LO 4
`define HIES_CODE_HI 7
`define HIES_CL_PAR 4
`define HIES_ER_SUM 6
`define HIES_ER_MEM 5
`define HIES_ER_DP 4
`define HIES_ER_SQ 3
`define HIES_ER_ILL 2
`define HIES_FC_WIDE 6
`define HIES_FC_ACK_HI 5
`define HIES_FC_ACK_LO 2
`define HIES_FC_FLUSH 1
`define HIES_FC_RESET 0
`define HIES_PC_W 10
`define HIES_HB_W 6
`define HIES_ZERO8 8'h00
`define HIES_ALL_CLR 5'h1f
`endif

/* File: tb/hies_irq_status_asserts.sv */
`include "hies_regs.svh"
`default_nettype none
module hies_irq_status_asserts (
  input wire logic core_clk,
  input wire logic reset,
  input wire logic clk_en,
  input wire logic host_rd,
  input wire logic [7:0] host_addr,
  input wire logic [7:0] host_rdata,
  input wire logic seq_wr,
  input wire logic [7:0] seq_addr,
  input wire logic [7:0] seq_wdata,
  input wire logic seq_pause,
  input wire logic [`HIES_HB_W-1:0] host_bus_error_bits,
  input wire logic irq_output_enable,
  input wire logic bus_master_allow,
  input wire logic soft_chip_reset,
  input wire logic bus_reset_pin_n,
  input wire logic host_irq_line_n,
  input wire logic [7:0] fifo_path_control
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (reset);
  // host read of the shared clear/error address
  sequence err_read;
    clk_en && host_rd && host_addr == 8'h92;
  endsequence
  // sequencer status write that raises attention
  sequence attn_write;
    clk_en && seq_wr && seq_addr == 8'h91 && seq_wdata[0];
  endsequence
  a_attn_pause: assert property (attn_write |-> seq_pause)
    else $error("no pause in the attention write cycle");
  a_irq_gate: assert property (
    clk_en && !(irq_output_enable && bus_master_allow) |=> host_irq_line_n)
    else $error("interrupt line low while gated off");
  a_rdata_idle: assert property (clk_en && !host_rd |=> host_rdata == 8'h00)
    else $error("read data not zero without a read");
  a_unmapped_read: assert property (
    clk_en && host_rd && (host_addr < 8'h91 || host_addr > 8'h93) |=> host_rdata == 8'h00)
    else $error("unmapped read not zero");
  a_err_layout: assert property (
    err_read |=> host_rdata[7] == 1'b0 && host_rdata[1:0] == 2'b00)
    else $error("unused error bits not zero");
  a_summary_or: assert property (
    err_read ##0 bus_reset_pin_n |=> host_rdata[6] == |$past(host_bus_error_bits))
    else $error("host bus summary is not the or of its bits");
  a_soft_fifo: assert property (clk_en && soft_chip_reset |=> fifo_path_control == 8'h00)
    else $error("fifo control not zeroed by soft reset");
  a_fifo_top: assert property (fifo_path_control[7] == 1'b0)
    else $error("fifo control top bit set");
endmodule
bind hies_irq_status hies_irq_status_asserts chk (.core_clk(core_clk), .reset(reset),
  .clk_en(clk_en), .host_rd(host_rd), .host_addr(host_addr), .host_rdata(host_rdata),
  .seq_wr(seq_wr), .seq_addr(seq_addr), .seq_wdata(seq_wdata), .seq_pause(seq_pause),
  .host_bus_error_bits(host_bus_error_bits), .irq_output_enable(irq_output_enable),
  .bus_master_allow(bus_master_allow), .soft_chip_reset(soft_chip_reset),
  .bus_reset_pin_n(bus_reset_pin_n), .host_irq_line_n(host_irq_line_n),
  .fifo_path_control(fifo_path_control));
`default_nettype wire

/* File: tb/hies_seq_model.sv */
`default_nettype none
module hies_seq_model (
  input wire logic go,
  input wire logic aim_clear,
  input wire logic [7:0] word,
  output logic seq_wr,
  output logic [7:0] seq_addr,
  output logic [7:0] seq_wdata
);
  // reason code rides in the same write as the attention flag; bits 3:2 never written
  always_comb begin
    seq_wr = go;
    seq_addr = aim_clear ? 8'h92 : 8'h91;
    seq_wdata = go ? {word[7:4], 2'b00, word[1:0]} : ~word;
  end
endmodule
`default_nettype wire

/* File: tb/test_host_interrupt_and_error_status.sv */
`include "hies_regs.svh"
`default_nettype none
module test_host_interrupt_and_error_status;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {
    logic [1:0] k;
    logic [7:0] a, d, want, mask;
  } hies_row_t;
  logic core_clk, reset, clk_en, host_wr, host_rd, seq_go, seq_wr, seq_pause, host_irq_line_n;
  logic breakpoint_off, array_access, external_array_select, array_arb_busy;
  logic illegal_fetch, store_parity_fail, datapath_parity_fail, memory_parity_fail;
  logic bus_reset_seen, bus_parity_seen, sel_timeout_seen, bus_free_seen;
  logic error_halt_disable, store_parity_check_off, datapath_parity_check_on;
  logic memory_parity_check_on, irq_output_enable, bus_master_allow, low_power_state;
  logic soft_chip_reset, bus_reset_pin_n;
  logic [7:0] host_addr, host_wdata, host_rdata, seq_addr, seq_wdata, fifo_path_control;
  logic [7:0] bus_events_a, bus_events_b, bus_event_mask_a, bus_event_mask_b;
  logic [`HIES_PC_W-1:0] seq_pc, break_addr;
  logic [`HIES_HB_W-1:0] host_bus_error_bits;
  int checks, mismatches;
  // kind 0 host write, 1 host read and compare, 2 sequencer write
  hies_row_t rows [15] = '{'{2, 8'h91, 8'h31, 0, 0}, '{1, 8'h91, 0, 8'h31, 8'hff},
    '{0, 8'h92, 8'h01, 0, 0}, '{1, 8'h91, 0, 8'h00, 8'h0f}, '{2, 8'h91, 8'h02, 0, 0},
    '{2, 8'h92, 8'h02, 0, 0}, '{1, 8'h91, 0, 8'h02, 8'h0f}, '{0, 8'h91, 8'h0f, 0, 0},
    '{1, 8'h91, 0, 8'h02, 8'h0f}, '{0, 8'h92, 8'h02, 0, 0}, '{1, 8'h91, 0, 8'h00, 8'h0f},
    '{1, 8'h50, 0, 8'h00, 8'hff}, '{1, 8'h92, 0, 8'h00, 8'hff}, '{0, 8'h93, 8'h40, 0, 0},
    '{1, 8'h93, 0, 8'h40, 8'hc0}};
  hies_seq_model seq (.go(seq_go), .aim_clear(host_addr == 8'h92), .word(host_wdata),
    .seq_wr, .seq_addr, .seq_wdata);
  hies_irq_status uut (.core_clk, .reset, .clk_en, .host_wr, .host_rd, .host_addr,
    .host_wdata, .host_rdata, .seq_wr, .seq_addr, .seq_wdata, .seq_pc, .break_addr,
    .breakpoint_off, .array_access, .external_array_select, .array_arb_busy, .seq_pause,
    .illegal_fetch, .store_parity_fail, .datapath_parity_fail, .memory_parity_fail,
    .host_bus_error_bits, .bus_reset_seen, .bus_parity_seen, .sel_timeout_seen,
    .bus_free_seen, .bus_events_a, .bus_events_b, .bus_event_mask_a, .bus_event_mask_b,
    .error_halt_disable, .store_parity_check_off, .datapath_parity_check_on,
    .memory_parity_check_on, .irq_output_enable, .bus_master_allow, .low_power_state,
    .soft_chip_reset, .bus_reset_pin_n, .host_irq_line_n, .fifo_path_control);
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  task automatic chk(input logic [7:0] seen, input logic [7:0] want);
    checks++;
    if (seen !== want) begin
      mismatches++;
      $display("BAD t=%0t seen=%h want=%h", $time, seen, want);
    end
  endtask
  task automatic idle(input int n);
    repeat (n) @(negedge core_clk);
  endtask
  // one request held for exactly one rising edge
  task automatic op(input int k, input logic [7:0] a, input logic [7:0] d);
    @(negedge core_clk);
    host_wr = (k == 0);
    host_rd = (k == 1);
    seq_go = (k == 2);
    host_addr = a;
    host_wdata = d;
    @(negedge core_clk);
    {host_wr, host_rd, seq_go} = 3'b000;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] want, input logic [7:0] m);
    op(1, a, 8'h00);
    chk(host_rdata & m, want);
  endtask
  task automatic complete_run;
    $display("checks=%0d mismatches=%0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  initial begin
    {host_wr, host_rd, seq_go, breakpoint_off, array_access, external_array_select} = '0;
    {array_arb_busy, illegal_fetch, store_parity_fail, datapath_parity_fail} = '0;
    {memory_parity_fail, bus_reset_seen, bus_parity_seen, sel_timeout_seen} = '0;
    {bus_free_seen, error_halt_disable, store_parity_check_off, low_power_state} = '0;
    {soft_chip_reset, host_addr, host_wdata, bus_events_a, bus_events_b} = '0;
    {bus_event_mask_a, bus_event_mask_b, seq_pc, host_bus_error_bits} = '0;
    {datapath_parity_check_on, memory_parity_check_on, irq_output_enable} = 3'b111;
    {bus_master_allow, bus_reset_pin_n, clk_en, reset} = 4'hf;
    break_addr = 10'h155;
    idle(8);
    reset = 1'b0;
    chk({7'h00, host_irq_line_n}, 8'h01);
    rd(8'h91, 8'h00, 8'hff);
    foreach (rows[i]) begin
      op(rows[i].k, rows[i].a, rows[i].d);
      if (rows[i].k == 1) chk(host_rdata & rows[i].mask, rows[i].want);
    end
    $display("rows done");
    // attention pulls the line two cycles later; any missing enable releases it
    op(2, 8'h91, 8'h51);
    idle(1);
    chk({7'h00, host_irq_line_n}, 8'h00);
    for (int g = 0; g < 3; g++) begin
      {irq_output_enable, bus_master_allow, low_power_state} = {g != 0, g != 1, g == 2};
      idle(2);
      chk({7'h00, host_irq_line_n}, 8'h01);
      {irq_output_enable, bus_master_allow, low_power_state} = 3'b110;
      idle(2);
      chk({7'h00, host_irq_line_n}, 8'h00);
    end
    op(0, 8'h92, 8'h01);
    op(2, 8'h91, 8'h02);
    low_power_state = 1'b1;
    idle(2);
    chk({6'h00, seq_pause, host_irq_line_n}, 8'h00);
    low_power_state = 1'b0;
    op(0, 8'h92, 8'h02);
    $display("irq done");
    // breakpoint match, then the same match with the compare disabled
    for (int b = 0; b < 2; b++) begin
      breakpoint_off = b[0];
      seq_pc = break_addr;
      idle(2);
      seq_pc = 10'h000;
      chk({7'h00, seq_pause}, {7'h00, !b[0]});
      rd(8'h91, b ? 8'h00 : 8'h08, 8'h0f);
      op(0, 8'h92, 8'h08);
      rd(8'h91, 8'h00, 8'h0f);
    end
    $display("breakpoint done");
    // the four bus faults and masked event a bit 0; clearing while the cause remains must not stick
    bus_event_mask_a = 8'h01;
    for (int i = 0; i < 5; i++) begin
      {bus_events_a[0], bus_free_seen, sel_timeout_seen, bus_parity_seen, bus_reset_seen} =
        5'(5'h01 << i);
      array_access = (i == 4);
      external_array_select = (i == 4);
      array_arb_busy = (i == 4);
      idle(2);
      chk({7'h00, seq_pause}, {7'h00, i != 4});
      array_arb_busy = 1'b0;
      idle(1);
      chk({7'h00, seq_pause}, 8'h01);
      op(0, 8'h92, 8'h04);
      rd(8'h91, 8'h04, 8'h0f);
      {bus_events_a[0], bus_free_seen, sel_timeout_seen, bus_parity_seen, bus_reset_seen} = '0;
      op(0, 8'h92, 8'h04);
      rd(8'h91, 8'h00, 8'h0f);
    end
    $display("bus events done");
    // parity errors with checks on, then with checks off
    for (int i = 0; i < 6; i++) begin
      {memory_parity_check_on, datapath_parity_check_on, store_parity_check_off} =
        (i < 3) ? 3'b110 : 3'b001;
      @(negedge core_clk);
      {memory_parity_fail, datapath_parity_fail, store_parity_fail} = 3'(3'b001 << (i % 3));
      idle(1);
      {memory_parity_fail, datapath_parity_fail, store_parity_fail} = 3'b000;
      idle(1);
      chk({7'h00, seq_pause}, {7'h00, i < 3});
      rd(8'h92, (i < 3) ? 8'(8'h08 << (i % 3)) : 8'h00, 8'hff);
      op(0, 8'h92, 8'h10);
      rd(8'h92, 8'h00, 8'hff);
      rd(8'h91, 8'h00, 8'h08);
    end
    // undefined instruction survives the clear bits; soft reset removes it
    illegal_fetch = 1'b1;
    idle(1);
    illegal_fetch = 1'b0;
    idle(1);
    op(0, 8'h92, 8'h1f);
    rd(8'h92, 8'h04, 8'hff);
    rd(8'h91, 8'h08, 8'h08);
    soft_chip_reset = 1'b1;
    idle(1);
    soft_chip_reset = 1'b0;
    idle(1);
    rd(8'h92, 8'h00, 8'hff);
    chk(fifo_path_control, 8'h00);
    host_bus_error_bits = 6'h04;
    idle(2);
    op(0, 8'h92, 8'h10);
    rd(8'h92, 8'h40, 8'hff);
    host_bus_error_bits = 6'h00;
    idle(2);
    rd(8'h92, 8'h00, 8'hff);
    chk({7'h00, host_irq_line_n}, 8'h01);
    $display("errors done");
    // external bus reset pin forces every clear and zeroes fifo control
    op(2, 8'h91, 8'h01);
    op(0, 8'h93, 8'h40);
    bus_reset_pin_n = 1'b0;
    idle(5);
    rd(8'h91, 8'h00, 8'h0f);
    chk(fifo_path_control, 8'h00);
    bus_reset_pin_n = 1'b1;
    idle(4);
    // a second core reset in mid-run after a fresh attention write
    op(2, 8'h91, 8'h01);
    reset = 1'b1;
    idle(2);
    reset = 1'b0;
    chk({7'h00, host_irq_line_n}, 8'h01);
    rd(8'h91, 8'h00, 8'hff);
    $display("resets done");
    complete_run();
  end
endmodule
`default_nettype wire
